// >>> design/ubm_mask_cmp.sv
//
// Purpose: Masked equality compare of one address half.
// Assumes: Pure combinational, same clock domain as the caller.
// Notes:   A set mask bit removes that bit from the compare.
//
module ubm_mask_cmp #(
  parameter int unsigned W = 16
) (
  // Operands
  input wire logic [W-1:0] addr_i,
  input wire logic [W-1:0] ref_i,
  input wire logic [W-1:0] mask_i,
  // Result
  output logic hit_o
);

  assign hit_o = &(mask_i | ~(addr_i ^ ref_i));

endmodule // ubm_mask_cmp

// >>> design/ubm_pair_sel.sv
//
// Purpose: Decode of a two-bit either/or/both selection field.
// Assumes: Code bit 0 selects the first kind, bit 1 the second.
// Notes:   Code 00 selects nothing, so the break never fires.
//
module ubm_pair_sel (
  // Field and observed cycle kind
  input wire logic [1:0] code_i,
  input wire logic second_kind_i,
  // Result
  output logic hit_o
);

  assign hit_o = second_kind_i ? code_i[1] : code_i[0];

endmodule // ubm_pair_sel

// >>> design/ubm_pkg.sv
//
// Purpose: Shared constants for the user break match unit.
// Assumes: Classic Wishbone register access, 32-bit data, byte addresses.
// Notes:   Each register takes one aligned word; narrow fields sit low.
//
package ubm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned WB_ADR_W = 8;
  localparam int unsigned WB_DAT_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned COND_W = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [WB_ADR_W-1:0] OFF_ADDR_HIGH = 8'h00;
  localparam logic [WB_ADR_W-1:0] OFF_ADDR_LOW = 8'h04;
  localparam logic [WB_ADR_W-1:0] OFF_MASK_HIGH = 8'h08;
  localparam logic [WB_ADR_W-1:0] OFF_MASK_LOW = 8'h0c;
  localparam logic [WB_ADR_W-1:0] OFF_COND = 8'h10;
  localparam logic [WB_ADR_W-1:0] OFF_INT_STATUS = 8'h14;
  localparam logic [WB_ADR_W-1:0] OFF_INT_MASK = 8'h18;

  // ----------------------------------------------------------------
  // Field positions of break_cycle_conditions
  // ----------------------------------------------------------------
  localparam int unsigned COND_MASTER_LSB = 6;
  localparam int unsigned COND_TYPE_LSB = 4;
  localparam int unsigned COND_DIR_LSB = 2;
  localparam int unsigned COND_SIZE_LSB = 0;

  // Operand size codes, shared by the field and the bus cycle
  localparam logic [1:0] SIZE_ANY = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LONG = 2'h3;

  // Selection code that never matches
  localparam logic [1:0] SEL_NONE = 2'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [HALF_W-1:0] RST_HALF = 16'h0000;
  localparam logic [COND_W-1:0] RST_COND = 8'h00;
  localparam logic RST_FLAG = 1'b0;

endpackage : ubm_pkg

// >>> design/ubm_top.sv
//
// Purpose: User break comparator with Wishbone registers and interrupt.
// Assumes: Observed bus cycles come from logic on clk_i, one pulse each.
// Notes:   The break request is registered, one cycle after the cycle.
//
// ------------------------------------------------------------------
// Break unit
// ------------------------------------------------------------------
// How it works
// R1: A 16-bit writable low half of the break address compares bus bits 15:0.
// R2: A 16-bit writable high half compares bus address bits 31:16.
// R3: A 16-bit mask picks high address bits left out of the compare.
// R4: A 16-bit mask picks low address bits left out of the compare.
// R5: Master field 01 breaks on CPU, 10 on DMA, 11 on both.
// R6: Type field 01 breaks on fetches, 10 on data, 11 on both.
// R7: Direction field 01 breaks on reads, 10 on writes, 11 on both.
// R8: Size field 00 ignores size, else byte, word or longword must match.
// R9: No break while master, type or direction field is 00; all reset 00.
// R10: Mask bit one ignores that address bit; zero demands equality.
// R11: Break only when address, master, type, direction and size all match.
module ubm_top
  import ubm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WB_DAT_W-1:0] wb_dat_i,
  output logic [WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Observed bus cycle
  input wire logic bus_valid_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic bus_dma_i,
  input wire logic bus_data_i,
  input wire logic bus_write_i,
  input wire logic [1:0] bus_size_i,
  // Break request and interrupt
  output logic break_req_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [HALF_W-1:0] addr_high;
    logic [HALF_W-1:0] addr_low;
    logic [HALF_W-1:0] mask_high;
    logic [HALF_W-1:0] mask_low;
    logic [COND_W-1:0] cond;
    logic int_status;
    logic int_mask;
    logic ack;
    logic [WB_DAT_W-1:0] rdata;
    logic brk;
  } ubm_state_t;

  ubm_state_t state_reg;
  ubm_state_t state_next;

  logic hi_hit;
  logic lo_hit;
  logic master_hit;
  logic type_hit;
  logic dir_hit;
  logic size_hit;
  logic match_now;
  logic bus_req;
  logic commit;
  logic [WB_DAT_W-1:0] rd_mux;

  // Byte-lane merge of a 16-bit register
  function automatic logic [HALF_W-1:0] lane16(input logic [HALF_W-1:0] old,
                                               input logic [HALF_W-1:0] data,
                                               input logic [1:0] sel);
    logic [HALF_W-1:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = data[7:0];
    end
    if (sel[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // High and low halves share one compare module
  ubm_mask_cmp #(.W(HALF_W)) u_cmp_high (
    .addr_i(bus_addr_i[31:16]),
    .ref_i(state_reg.addr_high),
    .mask_i(state_reg.mask_high),
    .hit_o(hi_hit)
  ); // [R2] [R3] [R10]

  ubm_mask_cmp #(.W(HALF_W)) u_cmp_low (
    .addr_i(bus_addr_i[15:0]),
    .ref_i(state_reg.addr_low),
    .mask_i(state_reg.mask_low),
    .hit_o(lo_hit)
  ); // [R1] [R4] [R10]

  ubm_pair_sel u_sel_master (
    .code_i(state_reg.cond[COND_MASTER_LSB +: 2]),
    .second_kind_i(bus_dma_i),
    .hit_o(master_hit)
  ); // [R5] [R9]

  ubm_pair_sel u_sel_type (
    .code_i(state_reg.cond[COND_TYPE_LSB +: 2]),
    .second_kind_i(bus_data_i),
    .hit_o(type_hit)
  ); // [R6] [R9]

  ubm_pair_sel u_sel_dir (
    .code_i(state_reg.cond[COND_DIR_LSB +: 2]),
    .second_kind_i(bus_write_i),
    .hit_o(dir_hit)
  ); // [R7] [R9]

  // Size is optional, unlike the three either/or fields
  assign size_hit = (state_reg.cond[COND_SIZE_LSB +: 2] == SIZE_ANY) ||
                    (state_reg.cond[COND_SIZE_LSB +: 2] == bus_size_i); // [R8]

  assign match_now = bus_valid_i & hi_hit & lo_hit & master_hit & type_hit &
                     dir_hit & size_hit; // [R11]

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    unique case (wb_adr_i)
      OFF_ADDR_HIGH: rd_mux[HALF_W-1:0] = state_reg.addr_high;
      OFF_ADDR_LOW: rd_mux[HALF_W-1:0] = state_reg.addr_low;
      OFF_MASK_HIGH: rd_mux[HALF_W-1:0] = state_reg.mask_high;
      OFF_MASK_LOW: rd_mux[HALF_W-1:0] = state_reg.mask_low;
      OFF_COND: rd_mux[COND_W-1:0] = state_reg.cond;
      OFF_INT_STATUS: rd_mux[0] = state_reg.int_status;
      OFF_INT_MASK: rd_mux[0] = state_reg.int_mask;
      default: rd_mux = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Ack comes one cycle after the request; writes and read-clear act
  // on the edge where the master sees ack, never before.
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign commit = bus_req & state_reg.ack;

  always_comb begin
    state_next = state_reg;
    state_next.ack = bus_req & ~state_reg.ack;
    state_next.rdata = '0;
    if (bus_req && !state_reg.ack && !wb_we_i) begin
      state_next.rdata = rd_mux;
    end
    if (commit && wb_we_i) begin
      unique case (wb_adr_i)
        OFF_ADDR_HIGH: begin
          state_next.addr_high = lane16(state_reg.addr_high, wb_dat_i[15:0],
                                        wb_sel_i[1:0]); // [R2]
        end
        OFF_ADDR_LOW: begin
          state_next.addr_low = lane16(state_reg.addr_low, wb_dat_i[15:0],
                                       wb_sel_i[1:0]); // [R1]
        end
        OFF_MASK_HIGH: begin
          state_next.mask_high = lane16(state_reg.mask_high, wb_dat_i[15:0],
                                        wb_sel_i[1:0]); // [R3]
        end
        OFF_MASK_LOW: begin
          state_next.mask_low = lane16(state_reg.mask_low, wb_dat_i[15:0],
                                       wb_sel_i[1:0]); // [R4]
        end
        OFF_COND: begin
          if (wb_sel_i[0]) begin
            state_next.cond = wb_dat_i[COND_W-1:0];
          end
        end
        OFF_INT_MASK: begin
          if (wb_sel_i[0]) begin
            state_next.int_mask = wb_dat_i[0];
          end
        end
        default: begin
          state_next.cond = state_reg.cond;
        end
      endcase
    end
    // Reading status clears only what the read returned: a break that landed
    // after the data was taken survives, and a break in this cycle still wins
    if (commit && !wb_we_i && wb_adr_i == OFF_INT_STATUS) begin
      state_next.int_status = state_reg.int_status & ~state_reg.rdata[0];
    end
    if (match_now) begin
      state_next.int_status = 1'b1;
    end
    state_next.brk = match_now; // [R11]
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg.addr_high <= RST_HALF;
      state_reg.addr_low <= RST_HALF;
      state_reg.mask_high <= RST_HALF;
      state_reg.mask_low <= RST_HALF;
      state_reg.cond <= RST_COND; // [R9]
      state_reg.int_status <= RST_FLAG;
      state_reg.int_mask <= RST_FLAG;
      state_reg.ack <= RST_FLAG;
      state_reg.rdata <= '0;
      state_reg.brk <= RST_FLAG;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_dat_o = state_reg.rdata;
  assign wb_ack_o = state_reg.ack;
  assign break_req_o = state_reg.brk;
  assign irq_o = state_reg.int_status & state_reg.int_mask;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Full-lane write handshake to one offset, committed at the ack edge
  sequence s_full_write(logic [WB_ADR_W-1:0] off);
    bus_req && wb_we_i && wb_adr_i == off && wb_sel_i[1:0] == 2'h3 && wb_ack_o;
  endsequence

  // An observed cycle that passes every non-address condition
  sequence s_kinds_ok;
    bus_valid_i && master_hit && type_hit && dir_hit && size_hit;
  endsequence

  property p_addr_low_write;
    s_full_write(OFF_ADDR_LOW) |=> state_reg.addr_low == $past(wb_dat_i[15:0]);
  endproperty
  a_addr_low_write: assert property (p_addr_low_write) // [R1]
    else $error("break_addr_low did not take the written value");

  property p_addr_high_write;
    s_full_write(OFF_ADDR_HIGH) |=> state_reg.addr_high == $past(wb_dat_i[15:0]);
  endproperty
  a_addr_high_write: assert property (p_addr_high_write) // [R2]
    else $error("break_addr_high did not take the written value");

  property p_high_mismatch;
    bus_valid_i &&
      (((bus_addr_i[31:16] ^ state_reg.addr_high) & ~state_reg.mask_high) != 16'h0000)
      |=> !break_req_o;
  endproperty
  a_high_mismatch: assert property (p_high_mismatch) // [R3]
    else $error("break raised on an unmasked high address mismatch");

  property p_low_mismatch;
    bus_valid_i &&
      (((bus_addr_i[15:0] ^ state_reg.addr_low) & ~state_reg.mask_low) != 16'h0000)
      |=> !break_req_o;
  endproperty
  a_low_mismatch: assert property (p_low_mismatch) // [R4]
    else $error("break raised on an unmasked low address mismatch");

  property p_master_sel;
    bus_valid_i &&
      !(bus_dma_i ? state_reg.cond[7] : state_reg.cond[6]) |=> !break_req_o;
  endproperty
  a_master_sel: assert property (p_master_sel) // [R5]
    else $error("break raised for a bus master that is not selected");

  property p_type_sel;
    bus_valid_i &&
      !(bus_data_i ? state_reg.cond[5] : state_reg.cond[4]) |=> !break_req_o;
  endproperty
  a_type_sel: assert property (p_type_sel) // [R6]
    else $error("break raised for an access type that is not selected");

  property p_dir_sel;
    bus_valid_i &&
      !(bus_write_i ? state_reg.cond[3] : state_reg.cond[2]) |=> !break_req_o;
  endproperty
  a_dir_sel: assert property (p_dir_sel) // [R7]
    else $error("break raised for a direction that is not selected");

  property p_size_sel;
    bus_valid_i && state_reg.cond[1:0] != 2'h0 && state_reg.cond[1:0] != bus_size_i
      |=> !break_req_o;
  endproperty
  a_size_sel: assert property (p_size_sel) // [R8]
    else $error("break raised for an operand size that is not selected");

  property p_zero_field_silent;
    (state_reg.cond[7:6] == 2'h0 || state_reg.cond[5:4] == 2'h0 ||
     state_reg.cond[3:2] == 2'h0) |=> !break_req_o;
  endproperty
  a_zero_field_silent: assert property (p_zero_field_silent) // [R9]
    else $error("break raised while a selection field is 00");

  property p_cond_reset;
    $fell(rst_i) |-> state_reg.cond == 8'h00;
  endproperty
  a_cond_reset: assert property (@(posedge clk_i) p_cond_reset) // [R9]
    else $error("break_cycle_conditions not zero after reset");

  property p_masked_match;
    s_kinds_ok ##0
      (((bus_addr_i ^ {state_reg.addr_high, state_reg.addr_low}) &
        ~{state_reg.mask_high, state_reg.mask_low}) == 32'h0) |=> break_req_o;
  endproperty
  a_masked_match: assert property (p_masked_match) // [R10]
    else $error("masked address equal but no break raised");

  property p_break_cause;
    break_req_o |-> $past(match_now) && $past(bus_valid_i);
  endproperty
  a_break_cause: assert property (p_break_cause) // [R11]
    else $error("break request without a matching bus cycle");

  property p_break_sets_irq;
    break_req_o && state_reg.int_mask |-> irq_o [*2];
  endproperty
  a_break_sets_irq: assert property (p_break_sets_irq) // [R11]
    else $error("unmasked break did not hold the interrupt");

endmodule // ubm_top

// >>> testbench/ubm_bus_model.sv
//
// Purpose: Model of the CPU and DMA masters whose bus cycles are watched.
// Assumes: One observed cycle lasts one clock, launched after a rising edge.
// Notes:   Between cycles the lines carry the inverse of the last value.
//
module ubm_bus_model (
  // Clock
  input wire logic clk_i,
  // Observed bus cycle
  output logic bus_valid_o,
  output logic [31:0] bus_addr_o,
  output logic bus_dma_o,
  output logic bus_data_o,
  output logic bus_write_o,
  output logic [1:0] bus_size_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    bus_valid_o = 1'b0;
    bus_addr_o = 32'h0;
    {bus_dma_o, bus_data_o, bus_write_o, bus_size_o} = 5'h0;
  end

  // Kind is {dma, data, write, size}; returns at the edge that samples it
  task automatic issue(input logic [31:0] a, input logic [4:0] k);
    @(posedge clk_i);
    bus_valid_o <= 1'b1;
    bus_addr_o <= a;
    {bus_dma_o, bus_data_o, bus_write_o, bus_size_o} <= k;
    @(posedge clk_i);
    bus_valid_o <= 1'b0;
    // Stale values would hide a design that samples outside the valid cycle
    bus_addr_o <= ~a;
    {bus_dma_o, bus_data_o, bus_write_o, bus_size_o} <= ~k;
  endtask
endmodule // ubm_bus_model

// >>> testbench/ubm_top_bench.sv
//
// Purpose: Self-checking bench of the user break match unit.
// Assumes: Wishbone ack comes in the cycle after the request.
// Notes:   Random register setups with hand corner cases mixed in.
//
module ubm_top_bench;
  import ubm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [WB_ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [WB_DAT_W-1:0] wb_dat_i, wb_dat_o;
  logic wb_ack_o, bus_valid_i, bus_dma_i, bus_data_i, bus_write_i;
  logic [31:0] bus_addr_i;
  logic [1:0] bus_size_i;
  logic break_req_o, irq_o;
  int failures = 0;
  int cmp_count = 0;
  logic [3:0] wb_sel_pend = 4'hf;

  ubm_top i_ubm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .bus_valid_i(bus_valid_i), .bus_addr_i(bus_addr_i), .bus_dma_i(bus_dma_i),
    .bus_data_i(bus_data_i), .bus_write_i(bus_write_i), .bus_size_i(bus_size_i),
    .break_req_o(break_req_o), .irq_o(irq_o));

  ubm_bus_model i_ubm_bus_model (.clk_i(clk_i), .bus_valid_o(bus_valid_i),
    .bus_addr_o(bus_addr_i), .bus_dma_o(bus_dma_i), .bus_data_o(bus_data_i),
    .bus_write_o(bus_write_i), .bus_size_o(bus_size_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: flag %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Wishbone single cycle and expectation
  // ----------------------------------------------------------------
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_sel_i <= wb_sel_pend;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  function automatic logic exp_hit(input logic [7:0] c, input logic [31:0] ra,
                                   input logic [31:0] msk, input logic [31:0] a,
                                   input logic [4:0] k);
    logic m, t, d;
    m = k[4] ? c[7] : c[6];
    t = k[3] ? c[5] : c[4];
    d = k[2] ? c[3] : c[2];
    return m && t && d && (((a ^ ra) & ~msk) == 32'h0) &&
           (c[1:0] == SIZE_ANY || c[1:0] == k[1:0]);
  endfunction

  task automatic setup(input logic [7:0] c, input logic [31:0] ra, input logic [31:0] msk);
    logic [31:0] rd;
    wb_xfer(1'b1, OFF_ADDR_HIGH, {16'h0, ra[31:16]}, rd);
    wb_xfer(1'b1, OFF_ADDR_LOW, {16'h0, ra[15:0]}, rd);
    wb_xfer(1'b1, OFF_MASK_HIGH, {16'h0, msk[31:16]}, rd);
    wb_xfer(1'b1, OFF_MASK_LOW, {16'h0, msk[15:0]}, rd);
    wb_xfer(1'b1, OFF_COND, {24'h0, c}, rd);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd, wd, ra, msk, a, lm;
    logic [7:0] c, adr;
    logic [4:0] k;
    logic [3:0] s;
    void'($urandom(32'h10d45253));
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Every register, and one unmapped place, reads zero after reset
    for (int i = 0; i < 8; i++) begin
      wb_xfer(1'b0, 8'(i * 4), 32'h0, rd);
      check_reg(rd, 32'h0);
    end
    // Address zero matches the reset address, only the 00 fields stop it
    i_ubm_bus_model.issue(32'h0, 5'h01);
    #1 check_flag(break_req_o, 1'b0);
    // Each writable register written once from reset with random byte lanes; 0x20 is unmapped
    for (int i = 0; i < 7; i++) begin
      adr = i == 5 ? OFF_INT_MASK : i == 6 ? 8'h20 : 8'(i * 4);
      wd = $urandom;
      s = 4'($urandom);
      lm = {16'h0, {8{s[1]}}, {8{s[0]}}};
      lm = adr == OFF_COND ? lm & 32'hff : adr == OFF_INT_MASK ? lm & 32'h1 : lm;
      wb_sel_pend = s;
      wb_xfer(1'b1, adr, wd, rd);
      wb_sel_pend = 4'hf;
      wb_xfer(1'b0, adr, 32'h0, rd);
      check_reg(rd, i == 6 ? 32'h0 : wd & lm);
    end
    for (int i = 0; i < 300; i++) begin
      c = 8'($urandom);
      ra = $urandom;
      msk = $urandom & $urandom;
      k = {3'($urandom), 2'($urandom_range(3, 1))};
      a = $urandom_range(1, 0) ? ra ^ ($urandom & msk) : $urandom;
      // First cases walk every code of every field with an exact address
      if (i < 16) begin
        c = {2'(i), 2'(i), 2'(i), 2'(i >> 2)};
        a = ra;
      end
      setup(c, ra, msk);
      i_ubm_bus_model.issue(a, k);
      #1 check_flag(break_req_o, exp_hit(c, ra, msk, a, k));
    end
    // Mid-run reset must bring the selection fields back to 00
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(1'b0, OFF_COND, 32'h0, rd);
    check_reg(rd, 32'h0);
    // Interrupt: sticky status, level output, mask, clear on read
    setup(8'hfc, $urandom, 32'hffffffff);
    wb_xfer(1'b1, OFF_INT_MASK, 32'h1, rd);
    wb_xfer(1'b0, OFF_INT_STATUS, 32'h0, rd);
    i_ubm_bus_model.issue($urandom, {3'($urandom), 2'h3});
    #1 check_flag(irq_o, 1'b1);
    @(posedge clk_i);
    #1 check_flag(break_req_o, 1'b0);
    wb_xfer(1'b0, OFF_INT_STATUS, 32'h0, rd);
    check_reg(rd, 32'h1);
    #1 check_flag(irq_o, 1'b0);
    wb_xfer(1'b1, OFF_INT_MASK, 32'h0, rd);
    i_ubm_bus_model.issue($urandom, 5'h1e);
    #1 check_flag(irq_o, 1'b0);
    wb_xfer(1'b0, OFF_INT_STATUS, 32'h0, rd);
    check_reg(rd, 32'h1);
    tally_and_finish();
  end
endmodule // ubm_top_bench
